// >>> src/uoc_port_power.sv
// usb option block: port power routing, over-current qualification,
// wake status and automatic d+ pull-up. assumes one clock, sync reset,
// and a register port with read data one cycle after the read strobe.
`timescale 1ns/1ps

module uoc_port_power
	import uoc_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	input wire logic [3:0] ohci_port_power_bit_i,
	input wire logic [3:0] ehci_port_power_bit_i,
	input wire logic overcurrent_sense_in_i,
	input wire logic vbus_above_threshold_i,
	output logic port_power_out1_o,
	output logic port_power_out2_o,
	output logic [3:0] ohci_overcurrent_o,
	output logic [3:0] ehci_overcurrent_o,
	output logic device_port_dplus_pullup_o,
	output logic host_port_select_o,
	output logic device_port_select_o,
	output logic pme_status_o,
	output logic irq_o
);
	// ==================================================================
	// decode helpers
	function automatic logic [1:0] map_route(input logic [1:0] code);
		logic [1:0] r;
		r = 2'h0;
		unique case (uoc_map_type'(code))
			UOC_MAP_NONE: r = 2'h0;
			UOC_MAP_GANGED: r = 2'h3;
			UOC_MAP_OUT1: r = 2'h1;
			UOC_MAP_OUT2: r = 2'h2;
		endcase
		return r;
	endfunction

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction

	// ==================================================================
	// declarations
	uoc_bus_req_type req;
	uoc_host_power_type hpow;
	logic [19:0] cap_reg;
	logic [1:0] mux_reg;
	logic sw_pullup_reg;
	logic pad_en_reg;
	logic [IRQ_WIDTH-1:0] irq_status_reg;
	logic [IRQ_WIDTH-1:0] irq_mask_reg;
	logic [31:0] rdata_reg;
	logic pme_reg;
	logic oc_sync;
	logic vbus_sync;
	logic vbus_prev_reg;
	logic oc_prev_reg;
	logic oc_active;
	logic vbus_valid_flag;
	logic vbus_change;
	logic oc_rise;
	logic [3:0] oc_report;
	logic [3:0] port_power;
	logic or_out1;
	logic or_out2;
	logic pullup_bit;
	logic wr_cap;
	logic wr_ctl;
	logic [IRQ_WIDTH-1:0] irq_event;
	logic [1:0] route;
	logic out1_reg;
	logic out2_reg;
	logic [3:0] ohci_oc_reg;
	logic [3:0] ehci_oc_reg;
	logic dplus_reg;

	assign req = '{addr: reg_addr_i, wdata: reg_wdata_i,
		wr: reg_wr_i, rd: reg_rd_i};
	assign hpow = '{ohci_port_power_bit: ohci_port_power_bit_i,
		ehci_port_power_bit: ehci_port_power_bit_i};
	assign wr_cap = req.wr && hit(req.addr, UOC_CAP_OFFSET);
	assign wr_ctl = req.wr && hit(req.addr, UOC_CTL_OFFSET);

	// ==================================================================
	// input synchronisers
	uoc_sync2 u_oc_sync (
		.core_clk_i(core_clk_i),
		.reset_i(reset_i),
		.async_i(overcurrent_sense_in_i),
		.sync_o(oc_sync)
	);

	uoc_sync2 u_vbus_sync (
		.core_clk_i(core_clk_i),
		.reset_i(reset_i),
		.async_i(vbus_above_threshold_i),
		.sync_o(vbus_sync)
	);

	// ==================================================================
	// capability register
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			cap_reg <= CAP_RESET[19:0];
		end else if (wr_cap) begin
			cap_reg <= req.wdata[CAP_LIVE_MSB:0];
		end else if (wr_ctl && !req.wdata[CTL_PAD_EN_BIT]) begin
			cap_reg[CAP_AUTO_PU_BIT] <= 1'b0;
		end
	end

	// ==================================================================
	// multiplex and option control registers
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			mux_reg <= MUX_RESET;
			sw_pullup_reg <= 1'b0;
		end else if (req.wr && hit(req.addr, UOC_MUX_OFFSET)) begin
			mux_reg <= req.wdata[1:0];
			sw_pullup_reg <= req.wdata[MUX_PULLUP_BIT];
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			pad_en_reg <= CTL_PAD_RESET;
		end else if (wr_cap && req.wdata[CAP_AUTO_PU_BIT]) begin
			pad_en_reg <= 1'b1;
		end else if (wr_ctl) begin
			pad_en_reg <= req.wdata[CTL_PAD_EN_BIT];
		end
	end

	// ==================================================================
	// over-current qualification and reporting
	assign oc_active = (oc_sync == cap_reg[CAP_OC_POL_BIT]);
	assign oc_report = cap_reg[CAP_OC_REP_LSB +: 4] & {4{oc_active}};

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			ohci_oc_reg <= 4'h0;
			ehci_oc_reg <= 4'h0;
			// start as if over-current were already seen: no false event
			oc_prev_reg <= 1'b1;
		end else begin
			ohci_oc_reg <= oc_report;
			ehci_oc_reg <= oc_report;
			oc_prev_reg <= oc_active;
		end
	end

	assign ohci_overcurrent_o = ohci_oc_reg;
	assign ehci_overcurrent_o = ehci_oc_reg;

	// ==================================================================
	// port power routing
	assign port_power = hpow.ohci_port_power_bit | hpow.ehci_port_power_bit;

	always_comb begin
		or_out1 = 1'b0;
		or_out2 = 1'b0;
		route = 2'h0;
		for (int p = 0; p < 4; p++) begin
			route = map_route(cap_reg[2*p +: 2]);
			or_out1 = or_out1 | (route[0] & port_power[p]);
			or_out2 = or_out2 | (route[1] & port_power[p]);
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			out1_reg <= ~CAP_RESET[CAP_PEN1_POL_BIT];
			out2_reg <= ~CAP_RESET[CAP_PEN2_POL_BIT];
		end else begin
			out1_reg <= ~(or_out1 ^ cap_reg[CAP_PEN1_POL_BIT]);
			out2_reg <= ~(or_out2 ^ cap_reg[CAP_PEN2_POL_BIT]);
		end
	end

	assign port_power_out1_o = out1_reg;
	assign port_power_out2_o = out2_reg;

	// ==================================================================
	// port ownership and d+ pull-up
	assign host_port_select_o = (mux_reg == MUX_HOST);
	assign device_port_select_o = (mux_reg == MUX_DEVICE);
	assign vbus_valid_flag = vbus_sync & pad_en_reg;
	assign pullup_bit = cap_reg[CAP_AUTO_PU_BIT] ? vbus_valid_flag
		: sw_pullup_reg;

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			dplus_reg <= 1'b0;
		end else begin
			dplus_reg <= device_port_select_o & pullup_bit & pad_en_reg;
		end
	end

	assign device_port_dplus_pullup_o = dplus_reg;

	// ==================================================================
	// wake status
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			vbus_prev_reg <= 1'b0;
		end else begin
			vbus_prev_reg <= vbus_valid_flag;
		end
	end

	assign vbus_change = vbus_valid_flag ^ vbus_prev_reg;
	assign oc_rise = oc_active & ~oc_prev_reg;

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			pme_reg <= 1'b0;
		end else if ((cap_reg[CAP_WAKE_OC_BIT] && oc_rise
			&& cap_reg[CAP_OC_REP_LSB + 3])
			|| (cap_reg[CAP_WAKE_VBUS_BIT] && vbus_change)) begin
			pme_reg <= 1'b1;
		end else if (req.wr && hit(req.addr, UOC_IRQ_STATUS_OFFSET)
			&& req.wdata[IRQ_PME_BIT]) begin
			pme_reg <= 1'b0;
		end
	end

	assign pme_status_o = pme_reg;

	// ==================================================================
	// interrupt status and mask
	assign irq_event[IRQ_OC_BIT] = oc_rise;
	assign irq_event[IRQ_VBUS_BIT] = vbus_change;
	assign irq_event[IRQ_PME_BIT] = 1'b0;

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			irq_status_reg <= '0;
		end else if (req.wr && hit(req.addr, UOC_IRQ_STATUS_OFFSET)) begin
			irq_status_reg <= (irq_status_reg & ~req.wdata[IRQ_WIDTH-1:0])
				| irq_event;
		end else begin
			irq_status_reg <= irq_status_reg | irq_event;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			irq_mask_reg <= '0;
		end else if (req.wr && hit(req.addr, UOC_IRQ_MASK_OFFSET)) begin
			irq_mask_reg <= req.wdata[IRQ_WIDTH-1:0];
		end
	end

	assign irq_o = |({irq_status_reg[IRQ_WIDTH-1:1] & irq_mask_reg[IRQ_WIDTH-1:1],
		irq_status_reg[0] & irq_mask_reg[0]}) | (pme_reg & irq_mask_reg[IRQ_PME_BIT]);

	// ==================================================================
	// read path
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			rdata_reg <= 32'h00000000;
		end else if (req.rd) begin
			rdata_reg <= 32'h00000000;
			unique case (req.addr)
				UOC_CAP_OFFSET: rdata_reg <= {12'h000, cap_reg};
				UOC_MUX_OFFSET: begin
					rdata_reg[MUX_VBUS_BIT] <= vbus_valid_flag;
					rdata_reg[MUX_PULLUP_BIT] <= pullup_bit;
					rdata_reg[1:0] <= mux_reg;
				end
				UOC_CTL_OFFSET: rdata_reg[CTL_PAD_EN_BIT] <= pad_en_reg;
				UOC_IRQ_STATUS_OFFSET: rdata_reg[IRQ_WIDTH-1:0] <=
					{pme_reg, irq_status_reg[1:0]};
				UOC_IRQ_MASK_OFFSET: rdata_reg[IRQ_WIDTH-1:0] <= irq_mask_reg;
				default: rdata_reg <= 32'h00000000;
			endcase
		end else begin
			rdata_reg <= 32'h00000000;
		end
	end

	assign reg_rdata_o = rdata_reg;
endmodule

// >>> src/uoc_pkg.sv
// package: register map, field positions and carrier types of the usb
// option block; assumes a single system clock and a plain register port.
package uoc_pkg;

	// ==================================================================
	// register offsets
	localparam logic [7:0] UOC_CAP_OFFSET = 8'h00;
	localparam logic [7:0] UOC_MUX_OFFSET = 8'h04;
	localparam logic [7:0] UOC_CTL_OFFSET = 8'h0c;
	localparam logic [7:0] UOC_IRQ_STATUS_OFFSET = 8'h10;
	localparam logic [7:0] UOC_IRQ_MASK_OFFSET = 8'h14;

	// ==================================================================
	// capability register fields
	localparam int CAP_WAKE_OC_BIT = 19;
	localparam int CAP_RSVD18_BIT = 18;
	localparam int CAP_WAKE_VBUS_BIT = 17;
	localparam int CAP_RSVD16_BIT = 16;
	localparam int CAP_AUTO_PU_BIT = 15;
	localparam int CAP_OC_POL_BIT = 14;
	localparam int CAP_OC_REP_LSB = 10;
	localparam int CAP_PEN2_POL_BIT = 9;
	localparam int CAP_PEN1_POL_BIT = 8;
	localparam int CAP_LIVE_MSB = 19;
	localparam logic [31:0] CAP_RESET = 32'h000003ea;

	// ==================================================================
	// multiplex and option control fields
	localparam int MUX_VBUS_BIT = 8;
	localparam int MUX_PULLUP_BIT = 2;
	localparam int CTL_PAD_EN_BIT = 7;
	localparam logic [1:0] MUX_RESET = 2'h0;
	localparam logic CTL_PAD_RESET = 1'b0;

	// ==================================================================
	// interrupt status bits
	localparam int IRQ_WIDTH = 3;
	localparam int IRQ_OC_BIT = 0;
	localparam int IRQ_VBUS_BIT = 1;
	localparam int IRQ_PME_BIT = 2;

	// ==================================================================
	// encodings
	typedef enum logic [1:0] {
		UOC_MAP_NONE = 2'h0,
		UOC_MAP_GANGED = 2'h1,
		UOC_MAP_OUT1 = 2'h2,
		UOC_MAP_OUT2 = 2'h3
	} uoc_map_type;

	localparam logic [1:0] MUX_DEVICE = 2'h3;
	localparam logic [1:0] MUX_HOST = 2'h2;

	// ==================================================================
	// carriers
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} uoc_bus_req_type;

	typedef struct packed {
		logic [3:0] ohci_port_power_bit;
		logic [3:0] ehci_port_power_bit;
	} uoc_host_power_type;

endpackage

// >>> src/uoc_sync2.sv
// two-flop synchroniser for one level from outside the clock domain.
// assumes the level is slow compared with the clock.
`timescale 1ns/1ps
module uoc_sync2 (
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic async_i,
	output logic sync_o
);
	logic meta_reg;
	logic sync_reg;

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
		end else begin
			meta_reg <= async_i;
			sync_reg <= meta_reg;
		end
	end

	assign sync_o = sync_reg;
endmodule

// >>> verif/uoc_switch_model.sv
// model: external power switch and over-current sensor of the port
// assumes the bench commands faults and how the sensor is wired
`timescale 1ns/1ps
module uoc_switch_model (
	input wire logic power1_i,
	input wire logic fault_i,
	input wire logic sense_active_high_i,
	output logic sense_o,
	output logic vbus_o
);
	// ==========
	// sensor and supply
	assign sense_o = fault_i ? sense_active_high_i : !sense_active_high_i;
	// vbus follows the first switch pin
	assign vbus_o = power1_i;
endmodule

// >>> verif/uoc_port_power_monitor.sv
// checker: power routing, reports, wake, selects and cap read-back
// assumes it is bound to uoc_port_power
`timescale 1ns/1ps
module uoc_port_power_mon
	import uoc_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [31:0] reg_rdata_o,
	input wire logic [3:0] ohci_port_power_bit_i,
	input wire logic [3:0] ehci_port_power_bit_i,
	input wire logic overcurrent_sense_in_i,
	input wire logic port_power_out1_o,
	input wire logic port_power_out2_o,
	input wire logic [3:0] ohci_overcurrent_o,
	input wire logic [3:0] ehci_overcurrent_o,
	input wire logic device_port_dplus_pullup_o,
	input wire logic host_port_select_o,
	input wire logic device_port_select_o,
	input wire logic pme_status_o
);
	// ==========
	// shadow of the capability register
	logic [19:0] cap_reg;
	logic [19:0] cap_d;
	logic sense_d;
	logic [3:0] pb;
	logic on1;
	logic on2;
	logic oc;
	logic stable;
	always_ff @(posedge core_clk_i) begin
		if (reset_i)
			cap_reg <= CAP_RESET[19:0];
		else if (reg_wr_i && reg_addr_i == UOC_CAP_OFFSET)
			cap_reg <= reg_wdata_i[19:0];
		else if (reg_wr_i && reg_addr_i == UOC_CTL_OFFSET && !reg_wdata_i[7])
			cap_reg[15] <= 1'b0;
	end
	always_ff @(posedge core_clk_i) begin
		cap_d <= cap_reg;
		sense_d <= overcurrent_sense_in_i;
	end
	always_comb begin
		pb = ohci_port_power_bit_i | ehci_port_power_bit_i;
		on1 = 1'b0;
		on2 = 1'b0;
		for (int i = 0; i < 4; i++) begin
			on1 = on1 | (pb[i] & (cap_reg[2*i] ^ cap_reg[2*i+1]));
			on2 = on2 | (pb[i] & cap_reg[2*i]);
		end
		oc = cap_reg[14] ? overcurrent_sense_in_i : !overcurrent_sense_in_i;
		stable = sense_d == overcurrent_sense_in_i && cap_d == cap_reg;
	end
	// ==========
	// properties
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (reset_i);
	property p_out1;
		port_power_out1_o == $past(on1 == cap_reg[8]);
	endproperty
	a_out1: assert property (p_out1) else $error("out1 wrong");
	property p_out2;
		port_power_out2_o == $past(on2 == cap_reg[9]);
	endproperty
	a_out2: assert property (p_out2) else $error("out2 wrong");
	property p_rep;
		stable [*4] |-> ohci_overcurrent_o == ({4{oc}} & cap_reg[13:10]);
	endproperty
	a_rep: assert property (p_rep) else $error("oc report");
	property p_ehci;
		ehci_overcurrent_o == ohci_overcurrent_o;
	endproperty
	a_ehci: assert property (p_ehci) else $error("ehci report");
	property p_wake;
		$rose(ohci_overcurrent_o[3]) && cap_reg[19] |-> ##[0:2] pme_status_o;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake");
	property p_pme;
		pme_status_o && !(reg_wr_i && reg_addr_i == UOC_IRQ_STATUS_OFFSET)
			|=> pme_status_o;
	endproperty
	a_pme: assert property (p_pme) else $error("pme lost");
	property p_pull;
		!device_port_select_o [*2] |-> !device_port_dplus_pullup_o;
	endproperty
	a_pull: assert property (p_pull) else $error("pull-up on");
	property p_mux;
		reg_wr_i && reg_addr_i == UOC_MUX_OFFSET |=>
			host_port_select_o == ($past(reg_wdata_i[1:0]) == MUX_HOST) &&
			device_port_select_o == ($past(reg_wdata_i[1:0]) == MUX_DEVICE);
	endproperty
	a_mux: assert property (p_mux) else $error("select wrong");
	property p_cap;
		reg_rd_i && reg_addr_i == UOC_CAP_OFFSET |=>
			reg_rdata_o == {12'h000, $past(cap_reg)};
	endproperty
	a_cap: assert property (p_cap) else $error("cap read");
endmodule
bind uoc_port_power uoc_port_power_mon u_mon (
	.core_clk_i(core_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
	.reg_rdata_o(reg_rdata_o), .ohci_port_power_bit_i(ohci_port_power_bit_i),
	.ehci_port_power_bit_i(ehci_port_power_bit_i),
	.overcurrent_sense_in_i(overcurrent_sense_in_i),
	.port_power_out1_o(port_power_out1_o),
	.port_power_out2_o(port_power_out2_o),
	.ohci_overcurrent_o(ohci_overcurrent_o),
	.ehci_overcurrent_o(ehci_overcurrent_o),
	.device_port_dplus_pullup_o(device_port_dplus_pullup_o),
	.host_port_select_o(host_port_select_o),
	.device_port_select_o(device_port_select_o),
	.pme_status_o(pme_status_o));

// >>> verif/testbench.sv
// testbench: registers, power routing, over-current, wake, pull-up
// assumes uoc_port_power, the switch model and the bound checker
`timescale 1ns/1ps
module testbench;
	import uoc_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [3:0] ohci = 4'h0;
	logic [3:0] ehci = 4'h0;
	logic fault = 1'b0;
	logic hi = 1'b0;
	logic [31:0] rdata;
	logic [3:0] oc_o;
	logic [3:0] oc_e;
	logic sense, vbus, p1, p2, pu, hsel, dsel, pme, irq;
	int fails = 0;
	int checked = 0;
	int cyc = 0;
	uoc_port_power u_dut (.core_clk_i(clk), .reset_i(rst),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
		.reg_rd_i(rd), .reg_rdata_o(rdata), .ohci_port_power_bit_i(ohci),
		.ehci_port_power_bit_i(ehci), .overcurrent_sense_in_i(sense),
		.vbus_above_threshold_i(vbus), .port_power_out1_o(p1),
		.port_power_out2_o(p2), .ohci_overcurrent_o(oc_o),
		.ehci_overcurrent_o(oc_e), .device_port_dplus_pullup_o(pu),
		.host_port_select_o(hsel), .device_port_select_o(dsel),
		.pme_status_o(pme), .irq_o(irq));
	uoc_switch_model u_model (.power1_i(p1), .fault_i(fault),
		.sense_active_high_i(hi), .sense_o(sense), .vbus_o(vbus));
	// ==========
	// tasks
	task automatic report_and_stop;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] m);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata & m, e);
	endtask
	task automatic pause(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// ==========
	// clock, timeout and tests
	initial begin
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			fails++;
			report_and_stop;
		end
	end
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		rd_reg(UOC_CAP_OFFSET, CAP_RESET, 32'hffffffff);
		rd_reg(8'h08, 32'h0, 32'hffffffff);
		wr_reg(UOC_CAP_OFFSET, 32'hffffffff);
		rd_reg(UOC_CAP_OFFSET, 32'h000fffff, 32'hffffffff);
		rd_reg(UOC_CTL_OFFSET, 32'h80, 32'h80);
		@(posedge clk) ohci <= 4'h1;
		for (int c = 0; c < 8; c++) begin
			wr_reg(UOC_CAP_OFFSET, {22'h0, {2{c[2]}}, 6'h0, c[1:0]});
			pause(2);
			chk(p1, (c[0] ^ c[1]) == c[2]);
			chk(p2, c[0] == c[2]);
		end
		@(posedge clk) ohci <= 4'h0;
		ehci <= 4'h8;
		wr_reg(UOC_CAP_OFFSET, 32'h000003aa);
		pause(2);
		chk({p1, p2}, 2'h2);
		wr_reg(UOC_CAP_OFFSET, 32'h00003c00);
		@(posedge clk) fault <= 1'b1;
		pause(5);
		chk({oc_o, oc_e}, 8'hff);
		wr_reg(UOC_CAP_OFFSET, 32'h00004400);
		pause(4);
		chk({oc_o, oc_e}, 8'h00);
		@(posedge clk) hi <= 1'b1;
		pause(4);
		chk({oc_o, oc_e}, 8'h11);
		@(posedge clk) hi <= 1'b0;
		for (int w = 0; w < 2; w++) begin
			@(posedge clk) fault <= 1'b0;
			wr_reg(UOC_CAP_OFFSET, {12'h0, w[0], 19'h02000});
			wr_reg(UOC_IRQ_STATUS_OFFSET, 32'h7);
			@(posedge clk) fault <= 1'b1;
			pause(6);
			chk(pme, w);
		end
		wr_reg(UOC_IRQ_MASK_OFFSET, 32'h4);
		#1;
		chk(irq, 1'b1);
		rd_reg(UOC_IRQ_STATUS_OFFSET, 32'h4, 32'h4);
		wr_reg(UOC_IRQ_STATUS_OFFSET, 32'h7);
		pause(1);
		chk({pme, irq}, 2'h0);
		wr_reg(UOC_IRQ_MASK_OFFSET, 32'h0);
		wr_reg(UOC_CAP_OFFSET, 32'h00008000);
		wr_reg(UOC_IRQ_STATUS_OFFSET, 32'h7);
		pause(4);
		chk(pme, 1'b0);
		wr_reg(UOC_CAP_OFFSET, 32'h00028100);
		pause(5);
		chk(pme, 1'b1);
		wr_reg(UOC_CAP_OFFSET, 32'h00008000);
		for (int m = 0; m < 4; m++) begin
			wr_reg(UOC_MUX_OFFSET, m);
			pause(4);
			chk({hsel, dsel, pu}, {m == 2, m == 3, m == 3});
		end
		wr_reg(UOC_CTL_OFFSET, 32'h0);
		pause(3);
		chk(pu, 1'b0);
		rd_reg(UOC_CAP_OFFSET, 32'h0, 32'h8000);
		wr_reg(UOC_MUX_OFFSET, 32'h7);
		wr_reg(UOC_CTL_OFFSET, 32'h80);
		pause(3);
		chk(pu, 1'b1);
		report_and_stop;
	end
endmodule
